// ===== design/dspcf_pkg.sv
// Purpose: constants for the audio processing configuration register bank
// Assumes: apb slave, 32-bit data, 16-bit registers in the low half of each word
// Notes:   register index constants; byte address is four times the index
package dspcf_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W  = 10;

  // register indices
  localparam logic [IDX_W-1:0] IDX_GATE_CTRL   = 10'h114;
  localparam logic [IDX_W-1:0] IDX_GATE_SLOPES = 10'h116;
  localparam logic [IDX_W-1:0] IDX_COMP_KNEE   = 10'h117;
  localparam logic [IDX_W-1:0] IDX_GATE_KNEE   = 10'h118;
  localparam logic [IDX_W-1:0] IDX_LOOPBACK    = 10'h11d;
  localparam logic [IDX_W-1:0] IDX_EQ_CTRL     = 10'h14f;
  localparam logic [IDX_W-1:0] IDX_EQ_LOW      = 10'h150;
  localparam logic [IDX_W-1:0] IDX_EQ_HIGH     = 10'h151;

  // values after reset
  localparam logic [15:0] RST_GATE_CTRL   = 16'h0000;
  localparam logic [15:0] RST_GATE_SLOPES = 16'h0000;
  localparam logic [15:0] RST_COMP_KNEE   = 16'h0000;
  localparam logic [15:0] RST_GATE_KNEE   = 16'h0000;
  localparam logic [15:0] RST_LOOPBACK    = 16'h0000;
  localparam logic [15:0] RST_EQ_CTRL     = 16'h0004;
  localparam logic [15:0] RST_EQ_LOW      = 16'h6318;
  localparam logic [15:0] RST_EQ_HIGH     = 16'h6300;

  // implemented bits of each register
  localparam logic [15:0] MSK_GATE_CTRL   = 16'h0090;
  localparam logic [15:0] MSK_GATE_SLOPES = 16'hffff;
  localparam logic [15:0] MSK_COMP_KNEE   = 16'h07ff;
  localparam logic [15:0] MSK_GATE_KNEE   = 16'h03ff;
  localparam logic [15:0] MSK_LOOPBACK    = 16'h0003;
  localparam logic [15:0] MSK_EQ_CTRL     = 16'h0007;
  localparam logic [15:0] MSK_EQ_LOW      = 16'hfffe;
  localparam logic [15:0] MSK_EQ_HIGH     = 16'hffc0;

  // field positions
  localparam int unsigned POS_GATE_ENABLE    = 7;
  localparam int unsigned POS_GATE_KNEE_OEN  = 4;
  localparam int unsigned POS_GATE_MIN_GAIN  = 12;
  localparam int unsigned POS_QR_THRESHOLD   = 10;
  localparam int unsigned POS_QR_DECAY       = 8;
  localparam int unsigned POS_EXPAND_SLOPE   = 6;
  localparam int unsigned POS_UPPER_SLOPE    = 3;
  localparam int unsigned POS_LOWER_SLOPE    = 0;
  localparam int unsigned POS_KNEE_INPUT     = 5;
  localparam int unsigned POS_KNEE_OUTPUT    = 0;
  localparam int unsigned POS_GKNEE_INPUT    = 5;
  localparam int unsigned POS_GKNEE_OUTPUT   = 0;
  localparam int unsigned POS_LOOP_ENABLE    = 1;
  localparam int unsigned POS_LOOP_SELECT    = 0;
  localparam int unsigned POS_EQ_SHARE       = 2;
  localparam int unsigned POS_EQ_SHARE_SRC   = 1;
  localparam int unsigned POS_EQ_ENABLE      = 0;
  localparam int unsigned POS_BAND_HI        = 11;
  localparam int unsigned POS_BAND_MID       = 6;
  localparam int unsigned POS_BAND_LO        = 1;

  // code limits and decode figures
  localparam logic [3:0] GATE_MIN_GAIN_RSV  = 4'hc;
  localparam logic [1:0] QR_DECAY_RSV       = 2'h3;
  localparam logic [2:0] UPPER_SLOPE_LIMIT  = 3'h5;
  localparam logic [2:0] UPPER_SLOPE_RSV    = 3'h6;
  localparam logic [2:0] LOWER_SLOPE_RSV    = 3'h5;
  localparam logic [5:0] KNEE_INPUT_MAX     = 6'h3c;
  localparam logic [4:0] KNEE_OUTPUT_RSV    = 5'h1f;
  localparam logic [4:0] BAND_GAIN_MAX      = 5'h18;
  localparam logic [5:0] BAND_GAIN_ZERO     = 6'h0c;
  localparam logic [5:0] QR_THRESHOLD_BASE  = 6'h0c;
  localparam logic [5:0] QR_THRESHOLD_STEP  = 6'h06;

endpackage

// ===== design/dspcf_regs.sv
// Purpose: apb register bank for the range controller, loopback router and equalizer
// Assumes: one clock, samples arrive synchronous to pclk with a valid strobe
// Notes:   pready is always high; read data is captured in the setup cycle
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
module dspcf_regs
  import dspcf_pkg::*;
#(
  parameter int unsigned SAMPLE_W = 24  // audio sample width
) (
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [ADDR_W-1:0]        paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic                          pready,
  output logic [31:0]                   prdata,
  output logic                          pslverr,
  // audio samples in
  input  wire logic                     sample_valid,
  input  wire logic [SAMPLE_W-1:0]      adc_left,
  input  wire logic [SAMPLE_W-1:0]      adc_right,
  input  wire logic [SAMPLE_W-1:0]      dac_left,
  input  wire logic [SAMPLE_W-1:0]      dac_right,
  // audio interface port out
  output logic                          aif_valid,
  output logic [SAMPLE_W-1:0]           aif_left,
  output logic [SAMPLE_W-1:0]           aif_right,
  // range controller settings
  output logic                          gate_enable,
  output logic [3:0]                    gate_min_gain,
  output logic [1:0]                    quick_release_threshold,
  output logic [5:0]                    quick_release_threshold_db,
  output logic [1:0]                    quick_release_decay,
  output logic [1:0]                    gate_expansion_slope,
  output logic [3:0]                    gate_expansion_factor,
  output logic [2:0]                    upper_compress_slope,
  output logic                          limiter_mode,
  output logic [2:0]                    lower_compress_slope,
  output logic [5:0]                    knee_input_level,
  output logic [4:0]                    knee_output_level,
  output logic [4:0]                    gate_knee_input_level,
  output logic                          gate_knee_input_active,
  output logic [4:0]                    gate_knee_output_level,
  output logic                          gate_knee_output_active,
  // equalizer settings
  output logic                          equalizer_enable,
  output logic                          eq_coeff_share,
  output logic                          eq_coeff_share_source,
  output logic                          left_coeff_set,
  output logic                          right_coeff_set,
  output logic [4:0][4:0]               left_band_gain,
  output logic [4:0][5:0]               left_band_gain_db,
  // misuse indication
  output logic                          reserved_code
);

  // whole state of the block
  typedef struct packed {
    logic [15:0]         gate_ctrl;
    logic [15:0]         gate_slopes;
    logic [15:0]         comp_knee;
    logic [15:0]         gate_knee;
    logic [15:0]         loopback;
    logic [15:0]         eq_ctrl;
    logic [15:0]         eq_low;
    logic [15:0]         eq_high;
    logic [31:0]         rdata;
    logic                slverr;
    logic                aif_valid;
    logic [SAMPLE_W-1:0] aif_left;
    logic [SAMPLE_W-1:0] aif_right;
  } dspcf_state_t;

  localparam dspcf_state_t RST_STATE = '{
    gate_ctrl:   RST_GATE_CTRL,
    gate_slopes: RST_GATE_SLOPES,
    comp_knee:   RST_COMP_KNEE,
    gate_knee:   RST_GATE_KNEE,
    loopback:    RST_LOOPBACK,
    eq_ctrl:     RST_EQ_CTRL,
    eq_low:      RST_EQ_LOW,
    eq_high:     RST_EQ_HIGH,
    rdata:       32'h0000_0000,
    slverr:      1'b0,
    aif_valid:   1'b0,
    aif_left:    '0,
    aif_right:   '0
  };

  dspcf_state_t          st_ff;      // registered state
  dspcf_state_t          nxt_st;     // next state
  logic [IDX_W-1:0]      idx;        // word index of the access
  logic                  hit;        // address names a register
  logic [15:0]           rd_val;     // selected register contents
  logic [15:0]           lane_msk;   // byte enables widened to bits
  logic                  setup_ph;   // first cycle of a transfer
  logic                  wr_take;    // write completes this edge
  logic [SAMPLE_W:0]     dac_sum;    // sum of both dacs, one bit wider
  logic [SAMPLE_W-1:0]   dac_avg;    // mean of both dacs

  // merge write data into the implemented bits enabled by the strobes
  function automatic logic [15:0] wr_merge(
    input logic [15:0] old_v,
    input logic [15:0] fld_msk,
    input logic [15:0] lanes,
    input logic [15:0] data
  );
    logic [15:0] m;
    m = fld_msk & lanes;
    return (old_v & ~m) | (data & m);
  endfunction

  // apb decode
  assign idx      = paddr[ADDR_W-1:2];
  assign lane_msk = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign setup_ph = psel && !penable;
  assign wr_take  = psel && penable && pwrite && hit;

  // mean of the dacs; the extra bit keeps the sum from wrapping
  assign dac_sum = {dac_left[SAMPLE_W-1], dac_left} + {dac_right[SAMPLE_W-1], dac_right};
  assign dac_avg = dac_sum[SAMPLE_W:1];

  // read select; bits outside a field are zero in storage already
  always_comb begin
    hit    = 1'b1;
    rd_val = 16'h0000;
    case (idx)
      IDX_GATE_CTRL:   rd_val = st_ff.gate_ctrl;
      IDX_GATE_SLOPES: rd_val = st_ff.gate_slopes;
      IDX_COMP_KNEE:   rd_val = st_ff.comp_knee;
      IDX_GATE_KNEE:   rd_val = st_ff.gate_knee;
      IDX_LOOPBACK:    rd_val = st_ff.loopback;
      IDX_EQ_CTRL:     rd_val = st_ff.eq_ctrl;
      IDX_EQ_LOW:      rd_val = st_ff.eq_low;
      IDX_EQ_HIGH:     rd_val = st_ff.eq_high;
      default:         hit = 1'b0;
    endcase
    // misaligned addresses are treated as unmapped
    if (paddr[1:0] != 2'h0) begin
      hit    = 1'b0;
      rd_val = 16'h0000;
    end
  end

  // next state: register writes, read capture and loopback
  always_comb begin
    nxt_st = st_ff;
    // read data and error are latched in setup so pready can stay high
    if (setup_ph) begin
      nxt_st.rdata  = pwrite ? 32'h0000_0000 : {16'h0000, rd_val};
      nxt_st.slverr = !hit;
    end
    // writes land only at the completing edge; masks keep spare bits zero
    if (wr_take) begin
      case (idx)
        IDX_GATE_CTRL: begin
          nxt_st.gate_ctrl = wr_merge(st_ff.gate_ctrl, MSK_GATE_CTRL, lane_msk,
                                      pwdata[15:0]);
        end
        IDX_GATE_SLOPES: begin
          nxt_st.gate_slopes = wr_merge(st_ff.gate_slopes, MSK_GATE_SLOPES, lane_msk,
                                        pwdata[15:0]);
        end
        IDX_COMP_KNEE: begin
          nxt_st.comp_knee = wr_merge(st_ff.comp_knee, MSK_COMP_KNEE, lane_msk,
                                      pwdata[15:0]);
        end
        IDX_GATE_KNEE: begin
          nxt_st.gate_knee = wr_merge(st_ff.gate_knee, MSK_GATE_KNEE, lane_msk,
                                      pwdata[15:0]);
        end
        IDX_LOOPBACK: begin
          nxt_st.loopback = wr_merge(st_ff.loopback, MSK_LOOPBACK, lane_msk,
                                     pwdata[15:0]);
        end
        IDX_EQ_CTRL: begin
          nxt_st.eq_ctrl = wr_merge(st_ff.eq_ctrl, MSK_EQ_CTRL, lane_msk,
                                    pwdata[15:0]);
        end
        IDX_EQ_LOW: begin
          nxt_st.eq_low = wr_merge(st_ff.eq_low, MSK_EQ_LOW, lane_msk,
                                   pwdata[15:0]);
        end
        IDX_EQ_HIGH: begin
          nxt_st.eq_high = wr_merge(st_ff.eq_high, MSK_EQ_HIGH, lane_msk,
                                    pwdata[15:0]);
        end
        default: begin
          nxt_st.eq_high = st_ff.eq_high;  // unmapped: nothing stored
        end
      endcase
    end
    // loopback router; aif_left and aif_right hold between sample strobes
    nxt_st.aif_valid = sample_valid;
    if (sample_valid) begin
      if (st_ff.loopback[POS_LOOP_ENABLE]) begin
        if (st_ff.loopback[POS_LOOP_SELECT]) begin
          nxt_st.aif_left  = dac_avg;
          nxt_st.aif_right = adc_right;
        end else begin
          nxt_st.aif_left  = adc_left;
          nxt_st.aif_right = dac_avg;
        end
      end else begin
        // normal record path
        nxt_st.aif_left  = adc_left;
        nxt_st.aif_right = adc_right;
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= RST_STATE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // bus answers; zero wait states
  assign pready  = 1'b1;
  assign prdata  = st_ff.rdata;
  assign pslverr = st_ff.slverr;

  // audio interface outputs
  assign aif_valid = st_ff.aif_valid;
  assign aif_left  = st_ff.aif_left;
  assign aif_right = st_ff.aif_right;

  // range controller fields
  assign gate_enable             = st_ff.gate_ctrl[POS_GATE_ENABLE];
  assign gate_min_gain           = st_ff.gate_slopes[POS_GATE_MIN_GAIN +: 4];
  assign quick_release_threshold = st_ff.gate_slopes[POS_QR_THRESHOLD +: 2];
  assign quick_release_decay     = st_ff.gate_slopes[POS_QR_DECAY +: 2];
  assign gate_expansion_slope    = st_ff.gate_slopes[POS_EXPAND_SLOPE +: 2];
  assign upper_compress_slope    = st_ff.gate_slopes[POS_UPPER_SLOPE +: 3];
  assign lower_compress_slope    = st_ff.gate_slopes[POS_LOWER_SLOPE +: 3];
  assign knee_input_level        = st_ff.comp_knee[POS_KNEE_INPUT +: 6];
  assign knee_output_level       = st_ff.comp_knee[POS_KNEE_OUTPUT +: 5];
  assign gate_knee_input_level   = st_ff.gate_knee[POS_GKNEE_INPUT +: 5];
  assign gate_knee_output_level  = st_ff.gate_knee[POS_GKNEE_OUTPUT +: 5];

  // threshold in dB: 12 plus 6 per step
  assign quick_release_threshold_db = QR_THRESHOLD_BASE
                                    + 6'(QR_THRESHOLD_STEP * {4'h0, quick_release_threshold});

  // expansion factor is a power of two, 1 means no expansion
  assign gate_expansion_factor = 4'(4'h1 << gate_expansion_slope);

  // slope code 5 on the upper region turns the compressor into a limiter
  assign limiter_mode = (upper_compress_slope == UPPER_SLOPE_LIMIT);

  // the gate knee only matters with the gate itself on
  assign gate_knee_input_active  = gate_enable;
  assign gate_knee_output_active = gate_enable
                                && st_ff.gate_ctrl[POS_GATE_KNEE_OEN];

  // equalizer control
  assign equalizer_enable      = st_ff.eq_ctrl[POS_EQ_ENABLE];
  assign eq_coeff_share        = st_ff.eq_ctrl[POS_EQ_SHARE];
  assign eq_coeff_share_source = st_ff.eq_ctrl[POS_EQ_SHARE_SRC];
  // coefficient set per channel: 0 left set, 1 right set
  assign left_coeff_set  = eq_coeff_share ? eq_coeff_share_source : 1'b0;
  assign right_coeff_set = eq_coeff_share ? eq_coeff_share_source : 1'b1;

  // band gain codes, band 1 in entry 0
  assign left_band_gain[0] = st_ff.eq_low[POS_BAND_HI +: 5];
  assign left_band_gain[1] = st_ff.eq_low[POS_BAND_MID +: 5];
  assign left_band_gain[2] = st_ff.eq_low[POS_BAND_LO +: 5];
  assign left_band_gain[3] = st_ff.eq_high[POS_BAND_HI +: 5];
  assign left_band_gain[4] = st_ff.eq_high[POS_BAND_MID +: 5];

  // gains as signed dB; reserved codes give meaningless values
  always_comb begin
    for (int b = 0; b < 5; b++) begin
      left_band_gain_db[b] = {1'b0, left_band_gain[b]} - BAND_GAIN_ZERO;
    end
  end

  // flag any reserved code left in a register; its effect is undefined
  always_comb begin
    reserved_code = (gate_min_gain >= GATE_MIN_GAIN_RSV)
                 || (quick_release_decay == QR_DECAY_RSV)
                 || (upper_compress_slope >= UPPER_SLOPE_RSV)
                 || (lower_compress_slope >= LOWER_SLOPE_RSV)
                 || (knee_input_level > KNEE_INPUT_MAX)
                 || (knee_output_level == KNEE_OUTPUT_RSV);
    for (int b = 0; b < 5; b++) begin
      if (left_band_gain[b] > BAND_GAIN_MAX) begin
        reserved_code = 1'b1;
      end
    end
  end

endmodule

// ===== tb/dspcf_regs_checker.sv
// Purpose: port-level checks for the processing config register bank
// Assumes: zero-wait apb slave, one clock domain
// Notes:   attached by bind, watches only the top ports
`timescale 1ns/100ps
module dspcf_regs_checker
  import dspcf_pkg::*;
(
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb slave
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pready,
  input wire logic              pslverr,
  // samples
  input wire logic              sample_valid,
  input wire logic              aif_valid,
  // range controller
  input wire logic              gate_enable,
  input wire logic [1:0]        quick_release_threshold,
  input wire logic [5:0]        quick_release_threshold_db,
  input wire logic [1:0]        gate_expansion_slope,
  input wire logic [3:0]        gate_expansion_factor,
  input wire logic              gate_knee_input_active,
  input wire logic              gate_knee_output_active,
  // equalizer
  input wire logic              equalizer_enable,
  input wire logic              eq_coeff_share,
  input wire logic              eq_coeff_share_source,
  input wire logic              left_coeff_set,
  input wire logic              right_coeff_set,
  input wire logic [4:0][4:0]   left_band_gain,
  input wire logic [4:0][5:0]   left_band_gain_db
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // no wait states, so a stuck pready would hang software
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  // threshold decode in 6dB steps from 12dB
  property p_thr; quick_release_threshold_db == 6'h0c + 6'h06 * {4'h0, quick_release_threshold};
  endproperty
  a_thr: assert property (p_thr) else $error("threshold decode off");
  property p_exp; gate_expansion_factor == (4'h1 << gate_expansion_slope); endproperty
  a_exp: assert property (p_exp) else $error("expansion factor off");
  // knee two follows the gate enable
  property p_gate; (gate_knee_input_active == gate_enable) && (gate_knee_output_active <= gate_enable);
  endproperty
  a_gate: assert property (p_gate) else $error("gate knee activity off");
  // one output pulse per lone sample
  property p_aif; sample_valid ##1 !sample_valid |-> aif_valid ##1 !aif_valid; endproperty
  a_aif: assert property (p_aif) else $error("output pulse off");
  property p_share; eq_coeff_share |-> left_coeff_set == eq_coeff_share_source
    && right_coeff_set == eq_coeff_share_source; endproperty
  a_share: assert property (p_share) else $error("shared set off");
  property p_own; !eq_coeff_share |-> !left_coeff_set && right_coeff_set; endproperty
  a_own: assert property (p_own) else $error("own sets off");
  property p_db; left_band_gain_db[0] == {1'b0, left_band_gain[0]} - 6'h0c; endproperty
  a_db: assert property (p_db) else $error("band db off");
  property p_err; psel && penable && paddr[1:0] != 2'b00 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("misaligned not refused");
  // a control write with lane 0 enabled lands one cycle later
  property p_wr; psel && penable && pwrite && pstrb[0] && paddr == {IDX_EQ_CTRL, 2'b00}
    |=> equalizer_enable == $past(pwdata[0]); endproperty
  a_wr: assert property (p_wr) else $error("enable write lost");
  c_loop: cover property (sample_valid ##1 aif_valid);
  c_err: cover property (psel && penable && pslverr);
  c_own: cover property (!eq_coeff_share && right_coeff_set);
endmodule

bind dspcf_regs dspcf_regs_checker u_checker (.*);

// ===== tb/audio_dsp_drc_eq_config_bench.sv
// Purpose: directed bench for the processing config register bank
// Assumes: zero-wait apb slave, 20 MHz pclk
// Notes:   each scenario task drives the block and judges its own results
`timescale 1ns/100ps
module audio_dsp_drc_eq_config_bench
  import dspcf_pkg::*;
;
  logic              pclk, presetn;                          // clock, reset
  logic              psel, penable, pwrite, pready, pslverr; // apb control
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rdat;                   // rdat: last read
  logic [3:0]        pstrb;
  logic              sample_valid, aif_valid, rerr;          // rerr: last error flag
  logic [23:0]       adc_left, adc_right, dac_left, dac_right, aif_left, aif_right;
  logic [3:0]        gate_min_gain, gate_expansion_factor;
  logic [1:0]        quick_release_threshold, quick_release_decay, gate_expansion_slope;
  logic [5:0]        quick_release_threshold_db, knee_input_level;
  logic [2:0]        upper_compress_slope, lower_compress_slope;
  logic [4:0]        knee_output_level, gate_knee_input_level, gate_knee_output_level;
  logic              gate_enable, limiter_mode, gate_knee_input_active, gate_knee_output_active;
  logic              equalizer_enable, eq_coeff_share, eq_coeff_share_source, reserved_code;
  logic              left_coeff_set, right_coeff_set;
  logic [4:0][4:0]   left_band_gain;
  logic [4:0][5:0]   left_band_gain_db;
  int                fails, compares;

  dspcf_regs DUT (.*);

  // free-running 50 ns clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk); // lets field outputs settle
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [15:0] d);
    apb(1'b1, {idx, 2'b00}, {16'h0000, d}, 4'hf);
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx, input logic [15:0] exp);
    apb(1'b0, {idx, 2'b00}, 32'h0, 4'hf);
    check($sformatf("reg %h", idx), {16'h0000, exp}, rdat);
    check("error flag", 32'h0, {31'h0, rerr});
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // reset values, unmapped and misaligned accesses
  task automatic t_reset;
    logic [IDX_W-1:0] idx [8] = '{10'h114, 10'h116, 10'h117, 10'h118, 10'h11d, 10'h14f,
                                  10'h150, 10'h151};
    logic [15:0]      val [8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0004, 16'h6318,
                                  16'h6300};
    for (int i = 0; i < 8; i++) begin
      rd(idx[i], val[i]);
    end
    apb(1'b0, 12'h480, 32'h0, 4'hf);
    check("unmapped", 32'h1, {rdat[30:0], rerr});
    apb(1'b0, 12'h459, 32'h0, 4'hf);
    check("misaligned", 32'h1, {31'h0, rerr});
    check("sets after reset", 32'h0, {30'h0, left_coeff_set, right_coeff_set});
  endtask

  // slope and gain fields, every threshold and expansion code, reserved codes
  task automatic t_drc;
    logic [15:0] rsv [4] = '{16'hc000, 16'h0300, 16'h0030, 16'h0005};
    for (int c = 0; c < 4; c++) begin
      wr(10'h116, {4'h0, 2'(c), 2'h0, 2'(c), 6'h00});
      check("threshold db", 32'd12 + 32'd6 * c, {26'h0, quick_release_threshold_db});
      check("expansion", 32'h1 << c, {28'h0, gate_expansion_factor});
    end
    wr(10'h116, 16'hb6ac);
    rd(10'h116, 16'hb6ac);
    check("fields", 32'hb6ac, {16'h0, gate_min_gain, quick_release_threshold,
      quick_release_decay, gate_expansion_slope, upper_compress_slope, lower_compress_slope});
    check("limiter", 32'h2, {30'h0, limiter_mode, reserved_code});
    for (int i = 0; i < 4; i++) begin
      wr(10'h116, rsv[i]);
      check("reserved", 32'h1, {31'h0, reserved_code});
    end
    wr(10'h116, 16'h0000);
  endtask

  // knee levels and when the gate knees apply
  task automatic t_knee;
    logic [15:0] gc [4] = '{16'h0000, 16'h0010, 16'h0080, 16'h0090};
    logic [1:0]  act [4] = '{2'b00, 2'b00, 2'b10, 2'b11};
    wr(10'h117, 16'hf79e);
    rd(10'h117, 16'h079e);
    check("knee", 32'hf3c, {20'h0, knee_input_level, knee_output_level, reserved_code});
    wr(10'h117, 16'h07a0);
    check("knee in reserved", 32'h1, {31'h0, reserved_code});
    wr(10'h117, 16'h001f);
    check("knee out reserved", 32'h1, {31'h0, reserved_code});
    wr(10'h117, 16'h0000);
    wr(10'h118, 16'hffff);
    rd(10'h118, 16'h03ff);
    check("gate knee", 32'h3ff, {22'h0, gate_knee_input_level, gate_knee_output_level});
    for (int i = 0; i < 4; i++) begin
      wr(10'h114, gc[i]);
      check("gate enable", {31'h0, act[i][1]}, {31'h0, gate_enable});
      check("gate active", {30'h0, act[i]},
            {30'h0, gate_knee_input_active, gate_knee_output_active});
    end
  endtask

  // loopback routing; select alone must not reroute
  task automatic t_loop;
    logic [15:0] mode [4] = '{16'h0000, 16'h0002, 16'h0003, 16'h0001};
    adc_left <= 24'h123456;
    adc_right <= 24'h654321;
    dac_left <= 24'h000005;
    dac_right <= 24'hfffff8; // sum -3 floors to -2
    for (int i = 0; i < 4; i++) begin
      wr(10'h11d, mode[i]);
      sample_valid <= 1'b1;
      @(posedge pclk);
      sample_valid <= 1'b0;
      @(posedge pclk); // pulse is sampled at the edge that ends it, before the flop clears
      check("aif valid", 32'h1, {31'h0, aif_valid});
      check("aif left", {8'h0, (i == 2) ? 24'hfffffe : 24'h123456}, {8'h0, aif_left});
      check("aif right", {8'h0, (i == 1) ? 24'hfffffe : 24'h654321}, {8'h0, aif_right});
      @(posedge pclk);
    end
  endtask

  // equalizer control codes, band placement, gains and byte lanes
  task automatic t_eq;
    for (int v = 0; v < 8; v++) begin
      wr(10'h14f, 16'(v));
      check("eq control", 32'(v), {29'h0, eq_coeff_share, eq_coeff_share_source,
                                   equalizer_enable});
      check("coeff sets", v[2] ? {30'h0, v[1], v[1]} : 32'h1,
            {30'h0, left_coeff_set, right_coeff_set});
    end
    wr(10'h150, 16'hc01b);
    rd(10'h150, 16'hc01a);
    wr(10'h151, 16'h0dff);
    rd(10'h151, 16'h0dc0);
    check("bands", {7'h0, 5'h17, 5'h01, 5'h0d, 5'h00, 5'h18}, {7'h0, left_band_gain});
    check("band db", {2'h0, 6'h0b, 6'h35, 6'h01, 6'h34, 6'h0c},
          {2'h0, left_band_gain_db});
    check("no reserved", 32'h0, {31'h0, reserved_code});
    apb(1'b1, 12'h544, 32'h0, 4'h2);
    rd(10'h151, 16'h00c0);
    wr(10'h150, 16'hc800);
    check("band reserved", 32'h1, {31'h0, reserved_code});
  endtask

  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, sample_valid} = 5'h0;
    {paddr, pwdata, pstrb} = '0;
    {adc_left, adc_right, dac_left, dac_right} = '0;
    fails = 0;
    compares = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_drc;
    t_knee;
    t_loop;
    t_eq;
    finish_test;
  end

  // watchdog: tests need well under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    finish_test;
  end
endmodule
